// [rtl/apd_regs.svh]
// timing constants for the page mode dram controller
`ifndef APD_REGS_SVH
`define APD_REGS_SVH
`define APD_CLK_NS 25
`define APD_RAC_NS 60
`define APD_RAS_MIN_NS 60
`define APD_RP_NS 40
`define APD_RCD_NS 20
`define APD_CAS_NS 20
`define APD_CP_NS 10
`define APD_CPN_NS 10
`define APD_CSR_NS 10
`define APD_CHR_NS 10
`define APD_RWD_NS 60
`define APD_CWD_NS 15
`define APD_WP_NS 10
`define APD_RWL_NS 20
`define APD_DH_NS 15
`define APD_WAKE_US 100
`define APD_WAKE_CYCLES 8
`define APD_ROWS 512
`define APD_REF_MS 8
`define APD_WAKE_CLKS 4000
`define APD_REF_INTERVAL 625
`define APD_CYC(ns) (((ns) + `APD_CLK_NS - 1) / `APD_CLK_NS)
`endif

// [rtl/apd_pkg.sv]
// types for the page mode dram controller
package apd_pkg;
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [9:0] multiplexed_address;
    logic din;
  } apd_pins_type;
  typedef struct packed {
    logic write;
    logic page;
    logic [19:0] addr;
    logic wdata;
  } apd_req_type;
  typedef enum logic [3:0] {
    APD_WAKE_WAIT = 4'h0,
    APD_IDLE = 4'h1,
    APD_ROW = 4'h2,
    APD_COL = 4'h3,
    APD_CAS_LOW = 4'h4,
    APD_PAGE = 4'h5,
    APD_PRE = 4'h6,
    APD_CBR_SETUP = 4'h7,
    APD_CBR_RAS = 4'h8,
    APD_CBR_END = 4'h9
  } apd_state_type;
endpackage

// [rtl/apd_ctrl.sv]
// host-side controller for a 1M x 1 asynchronous page mode dram
`timescale 1ns/1ps
`include "apd_regs.svh"

// What this block does
// - row then column halves on ten lines
// - page mode keeps row strobe low
// - no extended variant; REF_PERIOD_MS is not used
// - all 512 rows refreshed within 8ms
// - column strobe leads row strobe by two cycles, 50ns
// - refresh is column-before-row only, no row-only
// - wait 100us then nine row cycles; ready after the eighth
// - column high for precharge clears output
// - meet a read hold time
// - write pulse and lead times met
// - data held from later falling edge
// - refresh only starts from idle or wake wait, never hidden
module apd_ctrl #(
  parameter int REF_PERIOD_MS = `APD_REF_MS,
  parameter int WAKE_CYCLES = `APD_WAKE_CLKS,
  parameter int REF_INTERVAL = `APD_REF_INTERVAL
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire apd_pkg::apd_req_type req,
  output logic rd_valid,
  output logic rd_data,
  output logic ready_for_use,
  // dram pins
  output apd_pkg::apd_pins_type pins,
  input wire logic dout,
  input wire logic dout_oe
);
  import apd_pkg::*;

  // ----------------------------------------
  // timing counts
  // ----------------------------------------
  localparam logic [7:0] C_RAS = 8'(`APD_CYC(`APD_RAS_MIN_NS));
  localparam logic [7:0] C_RP = 8'(`APD_CYC(`APD_RP_NS));
  localparam logic [7:0] C_RCD = 8'(`APD_CYC(`APD_RCD_NS));
  localparam logic [7:0] C_CAS = 8'(`APD_CYC(`APD_RWD_NS));
  localparam logic [7:0] C_CP = 8'(`APD_CYC(`APD_CPN_NS));
  localparam logic [7:0] C_CSR = 8'(`APD_CYC(`APD_CSR_NS));
  localparam logic [7:0] C_CHR = 8'(`APD_CYC(`APD_CHR_NS) + 1);
  // REF_INTERVAL*512 cycles at 25ns is 8ms; WAKE_CYCLES is 100us

  apd_state_type state_q;
  logic [7:0] tmr_q;
  logic [15:0] wake_q;
  logic [3:0] wake_rows_q;
  logic [15:0] ref_tmr_q;
  logic ref_pend_q;
  logic [9:0] row_q;
  logic [9:0] col_q;
  logic oe_s1_q, oe_s2_q;
  logic write_q, wdata_q;
  logic ras_n_q, cas_n_q, we_n_q, din_q;
  logic [9:0] addr_q;
  logic dout_s1_q, dout_s2_q;
  logic rd_valid_q, rd_data_q;
  logic awake_q;

  function automatic logic tmr_done(input logic [7:0] t);
    tmr_done = (t == 8'h00);
  endfunction

  // page take only once column precharge has run out
  assign req_ready = (state_q == APD_IDLE) && awake_q && !ref_pend_q ||
                     (state_q == APD_PAGE) && tmr_done(tmr_q) && req.page &&
                     (req.addr[19:10] == row_q) && !ref_pend_q;
  assign pins = '{ras_n: ras_n_q, cas_n: cas_n_q, we_n: we_n_q,
                  multiplexed_address: addr_q, din: din_q};
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign ready_for_use = awake_q;

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      dout_s1_q <= 1'b0;
      dout_s2_q <= 1'b0;
      oe_s1_q <= 1'b0;
      oe_s2_q <= 1'b0;
    end else begin
      dout_s1_q <= dout;
      dout_s2_q <= dout_s1_q;
      oe_s1_q <= dout_oe;
      oe_s2_q <= oe_s1_q;
    end
  end

  // ----------------------------------------
  // refresh scheduler
  // ----------------------------------------
  // distributed refresh: one column-first cycle per interval covers every row in time
  always_ff @(posedge clk) begin
    if (srst) begin
      ref_tmr_q <= 16'h0000;
      ref_pend_q <= 1'b0;
    end else begin
      if (ref_tmr_q == 16'(REF_INTERVAL - 1)) begin
        ref_tmr_q <= 16'h0000;
        ref_pend_q <= 1'b1;
      end else begin
        ref_tmr_q <= ref_tmr_q + 16'h0001;
        if (state_q == APD_CBR_END && tmr_done(tmr_q)) begin
          ref_pend_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // main sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= APD_WAKE_WAIT;
      tmr_q <= 8'h00;
      wake_q <= 16'h0000;
      wake_rows_q <= 4'h0;
      awake_q <= 1'b0;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      din_q <= 1'b0;
      addr_q <= 10'h000;
      row_q <= 10'h000;
      col_q <= 10'h000;
      write_q <= 1'b0;
      wdata_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      if (!tmr_done(tmr_q)) begin
        tmr_q <= tmr_q - 8'h01;
      end
      case (state_q)
        APD_WAKE_WAIT: begin
          if (wake_q != 16'(WAKE_CYCLES - 1)) begin
            wake_q <= wake_q + 16'h0001;
          end else if (tmr_done(tmr_q)) begin
            state_q <= APD_CBR_SETUP;
            cas_n_q <= 1'b0;
            tmr_q <= C_CSR;
          end
        end
        APD_IDLE: begin
          if (ref_pend_q) begin
            cas_n_q <= 1'b0;
            tmr_q <= C_CSR;
            state_q <= APD_CBR_SETUP;
          end else if (req_valid && req_ready) begin
            row_q <= req.addr[19:10];
            col_q <= req.addr[9:0];
            addr_q <= req.addr[19:10];
            write_q <= req.write;
            wdata_q <= req.wdata;
            ras_n_q <= 1'b0;
            tmr_q <= C_RCD;
            state_q <= APD_ROW;
          end
        end
        APD_ROW, APD_COL: begin
          if (state_q == APD_ROW && tmr_done(tmr_q)) begin
            addr_q <= col_q;
            state_q <= APD_COL;
          end else if (state_q == APD_COL) begin
            cas_n_q <= 1'b0;
            we_n_q <= !write_q;
            din_q <= wdata_q;
            tmr_q <= C_CAS;
            state_q <= APD_CAS_LOW;
          end
        end
        APD_CAS_LOW: begin
          if (tmr_done(tmr_q)) begin
            if (!write_q) begin
              rd_valid_q <= 1'b1;
              rd_data_q <= dout_s2_q & oe_s2_q;
            end
            cas_n_q <= 1'b1;
            we_n_q <= 1'b1;
            tmr_q <= C_CP;
            state_q <= APD_PAGE;
          end
        end
        APD_PAGE: begin
          if (tmr_done(tmr_q)) begin
            if (req_valid && req_ready) begin
              addr_q <= req.addr[9:0];
              write_q <= req.write;
              wdata_q <= req.wdata;
              state_q <= APD_COL;
            end else begin
              ras_n_q <= 1'b1;
              tmr_q <= C_RP;
              state_q <= APD_PRE;
            end
          end
        end
        APD_PRE: begin
          if (tmr_done(tmr_q)) begin
            state_q <= APD_IDLE;
          end
        end
        APD_CBR_SETUP: begin
          if (tmr_done(tmr_q)) begin
            ras_n_q <= 1'b0;
            tmr_q <= C_CHR;
            state_q <= APD_CBR_RAS;
          end
        end
        APD_CBR_RAS: begin
          if (tmr_done(tmr_q)) begin
            cas_n_q <= 1'b1;
            tmr_q <= C_RAS - C_CHR;
            state_q <= APD_CBR_END;
          end
        end
        APD_CBR_END: begin
          if (tmr_done(tmr_q)) begin
            ras_n_q <= 1'b1;
            tmr_q <= C_RP;
            if (!awake_q) begin
              wake_rows_q <= wake_rows_q + 4'h1;
              if (wake_rows_q == 4'(`APD_WAKE_CYCLES - 1)) begin
                awake_q <= 1'b1;
              end
            end
            state_q <= awake_q ? APD_PRE : APD_WAKE_WAIT;
          end
        end
        default: begin
          state_q <= APD_IDLE;
        end
      endcase
    end
  end
endmodule

// [tb/apd_ctrl_assertions.sv]
// port checker for the dram controller
`timescale 1ns/1ps
module apd_chk #(
  parameter int REF_PERIOD_MS = 8,
  parameter int WAKE_CYCLES = 4000,
  parameter int REF_INTERVAL = 625
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // user side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire apd_pkg::apd_req_type req,
  input wire logic rd_valid,
  input wire logic rd_data,
  input wire logic ready_for_use,
  // dram side
  input wire apd_pkg::apd_pins_type pins,
  input wire logic dout,
  input wire logic dout_oe
);
  import apd_pkg::*;
  int falls_q;
  int gap_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // margin covers a request still in flight when refresh falls due
  always_ff @(posedge clk) begin
    falls_q <= srst ? 0 : falls_q + int'($fell(pins.ras_n));
    gap_q <= (srst || $fell(pins.ras_n)) ? 0 : gap_q + 1;
  end
  sequence s_col_first;
    $fell(pins.ras_n) && !pins.cas_n;
  endsequence
  a_col_lead_row: assert property (s_col_first |-> !$past(pins.cas_n))
    else $error("column strobe late");
  a_row_addr_hold: assert property ($fell(pins.ras_n) && pins.cas_n |=>
    $stable(pins.multiplexed_address)) else $error("row address moved");
  a_col_addr_hold: assert property ($fell(pins.cas_n) && !pins.ras_n |=>
    $stable(pins.multiplexed_address)) else $error("column address moved");
  a_ras_precharge: assert property ($rose(pins.ras_n) |-> pins.ras_n [*2])
    else $error("row precharge short");
  a_write_lead: assert property ($fell(pins.we_n) |=> !pins.cas_n && !pins.ras_n)
    else $error("write lead short");
  a_ready_gate: assert property (req_ready |-> ready_for_use)
    else $error("accept before wake");
  a_wake_rows: assert property ($rose(ready_for_use) |-> falls_q >= 8)
    else $error("wake cycles missing");
  a_refresh_gap: assert property (ready_for_use |-> gap_q <= REF_INTERVAL + 16)
    else $error("refresh overdue");
endmodule
bind apd_ctrl apd_chk #(.REF_PERIOD_MS(REF_PERIOD_MS), .WAKE_CYCLES(WAKE_CYCLES),
  .REF_INTERVAL(REF_INTERVAL)) apd_chk_i (.clk(clk), .srst(srst), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_data(rd_data),
  .ready_for_use(ready_for_use), .pins(pins), .dout(dout), .dout_oe(dout_oe));

// [tb/apd_dram_model.sv]
// behavioural 1M x 1 dram
`timescale 1ns/1ps
module apd_dram_model (
  // strobes and address
  input wire apd_pkg::apd_pins_type pins,
  // data out and misuse count
  output logic dout,
  output logic dout_oe,
  output int viol
);
  import apd_pkg::*;
  bit mem [bit [19:0]];
  logic [9:0] row;
  logic [19:0] a;
  int wake = 0;
  realtime t_cas = 0;
  initial begin
    dout = 1'b0;
    dout_oe = 1'b0;
    viol = 0;
  end
  always @(negedge pins.ras_n) begin
    wake++;
    if (pins.cas_n) row = pins.multiplexed_address;
    else if ($realtime - t_cas < 10) viol++;
  end
  always @(negedge pins.cas_n) begin
    t_cas = $realtime;
    if (!pins.ras_n) begin
      a = {row, pins.multiplexed_address};
      if (wake < 8) viol++;
      if (!pins.we_n) mem[a] = pins.din;
      else begin
        #20 dout = mem.exists(a) && mem[a];
        dout_oe = 1'b1;
      end
    end
  end
  // address from the pins, so a strobe pair falling together cannot use a stale column
  always @(negedge pins.we_n)
    if (!pins.cas_n && !pins.ras_n) mem[{row, pins.multiplexed_address}] = pins.din;
  // released line shows the inverse, not a stale bit
  always @(posedge pins.cas_n) begin
    dout_oe = 1'b0;
    dout = ~dout;
  end
endmodule

// [tb/apd_ctrl_tb.sv]
// bench for the dram controller
`timescale 1ns/1ps
module apd_ctrl_tb;
  import apd_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  apd_req_type req = '0;
  logic req_ready, rd_valid, rd_data, ready_for_use, dout, dout_oe;
  apd_pins_type pins;
  int viol, err_total = 0, n_checks = 0, cbr_n = 0;
  apd_ctrl #(.WAKE_CYCLES(20), .REF_INTERVAL(50)) apd_ctrl_i (.clk(clk), .srst(srst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_valid(rd_valid),
    .rd_data(rd_data), .ready_for_use(ready_for_use), .pins(pins), .dout(dout),
    .dout_oe(dout_oe));
  apd_dram_model apd_dram_model_i (.pins(pins), .dout(dout), .dout_oe(dout_oe), .viol(viol));
  always #12.5 clk = ~clk;
  always @(negedge pins.ras_n) if (!pins.cas_n) cbr_n++;
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic xfer(input logic w, input logic p, input logic [19:0] ad, input logic d);
    int n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{write: w, page: p, addr: ad, wdata: d};
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 2000);
    chk(n < 2000, "request not taken");
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] ad, input logic p, input logic exp);
    int n = 0;
    xfer(1'b0, p, ad, 1'b0);
    while (rd_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(rd_valid === 1'b1 && rd_data === exp, "read data");
  endtask
  task automatic t_wake;
    int n = 0;
    chk(ready_for_use === 1'b0, "ready early");
    while (ready_for_use !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 20 && ready_for_use === 1'b1, "wake time");
  endtask
  task automatic t_data;
    logic [19:0] ad [4] = '{20'h00000, 20'hFFFFF, 20'h003FF, 20'hFFC00};
    foreach (ad[i]) xfer(1'b1, 1'b0, ad[i], ~i[0]);
    foreach (ad[i]) rd(ad[i], 1'b0, ~i[0]);
  endtask
  task automatic t_page;
    xfer(1'b1, 1'b1, 20'h55401, 1'b1);
    xfer(1'b1, 1'b1, 20'h55402, 1'b0);
    rd(20'h55401, 1'b1, 1'b1);
    rd(20'h55402, 1'b1, 1'b0);
  endtask
  task automatic t_refresh;
    int c = cbr_n;
    repeat (160) @(posedge clk);
    chk(cbr_n - c >= 3, "refresh missing");
    rd(20'h00000, 1'b0, 1'b1);
  endtask
  task final_report;
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_wake();
    t_data();
    t_page();
    t_refresh();
    chk(viol == 0, "device misuse");
    final_report();
  end
  initial begin
    #(20000 * 25);
    err_total++;
    final_report();
  end
endmodule
